// file: shared/cfcs_pkg.sv
package cfcs_pkg;

  // ***************************************************
  // address and command
  // ***************************************************
  localparam logic [4:0] ADDR_FIXED     = 5'h1A;
  localparam int         CMD_OP_BIT     = 7;
  localparam int         NUM_BYTES      = 7;

  // ***************************************************
  // register byte offsets
  // ***************************************************
  localparam logic [6:0] OFS_REVISION   = 7'h00;
  localparam logic [6:0] OFS_RSVD_ONE   = 7'h01;
  localparam logic [6:0] OFS_UPPER_DIV  = 7'h02;
  localparam logic [6:0] OFS_RSVD_THREE = 7'h03;
  localparam logic [6:0] OFS_LOWER_DIV  = 7'h04;
  localparam logic [6:0] OFS_CHIP_EN    = 7'h05;
  localparam logic [6:0] OFS_OUT_EN_LO  = 7'h06;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int REV_LSB      = 3;
  localparam int GROUP_ON_BIT = 5;
  localparam int CHIP_EN_BIT  = 7;
  localparam int RATIO_W      = 4;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [7:0] RST_REVISION   = 8'h00;
  localparam logic [7:0] RST_RSVD_ONE   = 8'h20;
  localparam logic [7:0] RST_DIV_CTRL   = 8'h30;
  localparam logic [7:0] RST_RSVD_THREE = 8'h00;
  localparam logic [7:0] RST_CHIP_EN    = 8'hFF;
  localparam logic [7:0] RST_OUT_EN_LO  = 8'hF0;
  localparam logic [7:0] RO_MASK_CHIP   = 8'h40;

  // ***************************************************
  // ratio table
  // ***************************************************
  localparam logic [3:0] RATIO_MAX_CODE = 4'hA;

  function automatic logic [6:0] cfcs_ratio(input logic [3:0] code);
    case (code)
      4'h0:    cfcs_ratio = 7'd1;
      4'h1:    cfcs_ratio = 7'd2;
      4'h2:    cfcs_ratio = 7'd4;
      4'h3:    cfcs_ratio = 7'd5;
      4'h4:    cfcs_ratio = 7'd8;
      4'h5:    cfcs_ratio = 7'd10;
      4'h6:    cfcs_ratio = 7'd16;
      4'h7:    cfcs_ratio = 7'd20;
      4'h8:    cfcs_ratio = 7'd32;
      4'h9:    cfcs_ratio = 7'd40;
      4'hA:    cfcs_ratio = 7'd80;
      default: cfcs_ratio = 7'd1;
    endcase
  endfunction

  typedef enum logic [2:0] {
    CFCS_IDLE, CFCS_ADDR, CFCS_CMD, CFCS_WDATA, CFCS_RDATA, CFCS_ACK, CFCS_RACK
  } cfcs_state_t;

endpackage

// file: shared/cfcs_div_if.sv
`timescale 1ns/1ps
interface cfcs_div_if;
  logic [3:0] ratio_sel;
  logic       group_on;
  logic       div_out;
  modport ctrl (output ratio_sel, output group_on, input div_out);
  modport div  (input ratio_sel, input group_on, output div_out);
endinterface

// file: verilog/cfcs_divider.sv
`timescale 1ns/1ps
module cfcs_divider
  import cfcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // clock to divide
  input wire logic src_clk_en,
  // control and output
  cfcs_div_if.div  dif
);

  logic [6:0] ratio;
  logic [6:0] cnt;
  logic       q;

  assign ratio = cfcs_ratio(dif.ratio_sel);

  // ratio applies at once, glitch allowed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 7'd0;
      q   <= 1'b0;
    end else if (!dif.group_on) begin
      cnt <= 7'd0;
      q   <= 1'b0;
    end else if (src_clk_en) begin
      // one source edge per pulse, so ratio pulses per half period
      if (cnt >= ratio - 7'd1) begin
        cnt <= 7'd0;
        q   <= ~q;
      end else begin
        cnt <= cnt + 7'd1;
      end
    end
  end

  assign dif.div_out = q;

endmodule

// file: verilog/cfcs_slave.sv
// What this block does
// R01 - answer only address 11010 plus the two address-select pin levels
// R02 - bit after address: 0 writes into device, 1 reads from it
// R03 - fast-mode 7-bit slave; master keeps clock at or below 400 kbit/s
// R04 - command byte top bit must be 1 for byte or word access
// R05 - command low seven bits give the register byte offset
// R06 - byte commands 80h through 86h address bytes 0 through 6
// R07 - word access at offset n moves byte n then byte n+1
// R08 - byte 0 read-only, revision code in bits 5 to 3
// R09 - byte 2 bit 5 enables upper group, outputs 9 to 5; resets 1
// R10 - byte 2 bits 3 to 0 select upper ratio; reset zero
// R11 - byte 4 bit 5 enables lower group, outputs 4 to 0; resets 1
// R12 - byte 4 bits 3 to 0 select lower ratio; reset zero
// R13 - byte 5 bit 7 chip enable; 0 gives quiescent state; resets 1
// R14 - byte 5 bits 5 to 2 enable outputs 9 to 6; reset 1
// R15 - bus traffic never disturbs outputs a write leaves unchanged
// R16 - new ratio applies immediately, no group resynchronisation
// R17 - after reset all outputs enabled, both groups divide by one
// R18 - disabled output stops driving; both lines pulled to supply
// R19 - ratio codes 0 to 10 give 1,2,4,5,8,10,16,20,32,40,80
// R20 - byte 5 bits 1,0 and byte 6 bits 7-4 enable outputs 5,4,3-0
// R21 - write: start, address, command, one or two data bytes, stop
// R22 - read: set offset by write, repeated start, bytes, nack, stop
// R23 - master writes reserved bits with their power-up values
`timescale 1ns/1ps
module cfcs_slave
  import cfcs_pkg::*;
#(
  parameter logic [2:0] REVISION_CODE = 3'h5  // arbitrary value
)(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // address straps
  input  wire logic       addr_sel_pin_hi,
  input  wire logic       addr_sel_pin_lo,
  // serial link
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // clock fanout
  input  wire logic       src_clk_en,
  output logic [9:0]      clk_out_pos,
  output logic [9:0]      clk_out_neg,
  output logic [9:0]      out_drive_on,
  output logic            chip_on
);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic       scl_q;
  logic       sda_q;
  logic       scl_prev;
  logic       sda_prev;
  logic [1:0] strap;
  logic [5:0] strap_s;

  // R03 pin synchronisers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      if (scl_s[1] == scl_s[2])
        scl_q <= scl_s[2];
      if (sda_s[1] == sda_s[2])
        sda_q <= sda_s[2];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      strap_s  <= 6'h00;
      strap    <= 2'h0;
    end else begin
      scl_prev <= scl_q;
      sda_prev <= sda_q;
      strap_s  <= {strap_s[3:0], addr_sel_pin_hi, addr_sel_pin_lo};
      if (strap_s[3:2] == strap_s[5:4])
        strap <= strap_s[5:4];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_q & ~scl_prev;
  assign scl_fall  = ~scl_q & scl_prev;
  assign start_det = scl_q & scl_prev & sda_prev & ~sda_q;
  assign stop_det  = scl_q & scl_prev & ~sda_prev & sda_q;

  // ***************************************************
  // register bytes
  // ***************************************************
  logic [7:0] regs [NUM_BYTES];
  logic [7:0] rd_byte;
  logic [6:0] ofs;

  // R06 offsets 0 to 6
  always_comb begin
    rd_byte = 8'h00;
    if (ofs < 7'(NUM_BYTES))
      rd_byte = regs[ofs[2:0]];
    // R08 revision read-only
    if (ofs == OFS_REVISION)
      rd_byte = 8'(REVISION_CODE) << REV_LSB;
  end

  // ***************************************************
  // protocol engine
  // ***************************************************
  cfcs_state_t state;
  cfcs_state_t ack_next;
  logic [7:0]  shreg;
  logic [3:0]  bitn;
  logic        wr_stb;
  logic [7:0]  wr_val;
  logic [6:0]  wr_ofs;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= CFCS_IDLE;
      ack_next <= CFCS_IDLE;
      shreg    <= 8'h00;
      bitn     <= 4'h0;
      ofs      <= 7'h00;
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
      wr_stb   <= 1'b0;
      wr_val   <= 8'h00;
      wr_ofs   <= 7'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_det) begin
        // R22 repeated start keeps offset
        state    <= CFCS_ADDR;
        bitn     <= 4'h0;
        sda_oe   <= 1'b0;
      end else if (stop_det) begin
        state  <= CFCS_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          CFCS_IDLE: sda_oe <= 1'b0;
          CFCS_ADDR, CFCS_CMD, CFCS_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_q};
              bitn  <= bitn + 4'h1;
            end else if (scl_fall && bitn == 4'h8) begin
              bitn <= 4'h0;
              if (state == CFCS_ADDR) begin
                // R01 address match
                if (shreg[7:3] == ADDR_FIXED && shreg[2:1] == strap) begin
                  // R02 direction bit
                  ack_next <= shreg[0] ? CFCS_RDATA : CFCS_CMD;
                  sda_out  <= 1'b0;
                  sda_oe   <= 1'b1;
                  state    <= CFCS_ACK;
                end else begin
                  state <= CFCS_IDLE;
                end
              end else if (state == CFCS_CMD) begin
                // R04 R05 command selects offset
                if (shreg[CMD_OP_BIT]) begin
                  ofs      <= shreg[6:0];
                  ack_next <= CFCS_WDATA;
                  sda_out  <= 1'b0;
                  sda_oe   <= 1'b1;
                  state    <= CFCS_ACK;
                end else begin
                  state <= CFCS_IDLE;
                end
              end else begin
                // R21 R07 data write, offset steps
                wr_stb   <= 1'b1;
                wr_val   <= shreg;
                wr_ofs   <= ofs;
                ofs      <= ofs + 7'h1;
                ack_next <= CFCS_WDATA;
                sda_out  <= 1'b0;
                sda_oe   <= 1'b1;
                state    <= CFCS_ACK;
              end
            end
          end
          CFCS_ACK: begin
            if (scl_fall) begin
              state <= ack_next;
              if (ack_next == CFCS_RDATA) begin
                shreg   <= {rd_byte[6:0], 1'b0};
                sda_out <= rd_byte[7];
                sda_oe  <= ~rd_byte[7];
                bitn    <= 4'h1;
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          CFCS_RDATA: begin
            if (scl_fall) begin
              if (bitn == 4'h8) begin
                sda_oe <= 1'b0;
                ofs    <= ofs + 7'h1;
                state  <= CFCS_RACK;
              end else begin
                sda_out <= shreg[7];
                sda_oe  <= ~shreg[7];
                shreg   <= {shreg[6:0], 1'b0};
                bitn    <= bitn + 4'h1;
              end
            end
          end
          CFCS_RACK: begin
            // R22 nack ends read
            if (scl_rise) begin
              ack_next <= sda_q ? CFCS_IDLE : CFCS_RDATA;
              state    <= sda_q ? CFCS_IDLE : CFCS_ACK;
            end
          end
          default: state <= CFCS_IDLE;
        endcase
      end
    end
  end

  // ***************************************************
  // register write
  // ***************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // R17 power-on defaults
      regs[0] <= RST_REVISION;
      regs[1] <= RST_RSVD_ONE;
      regs[2] <= RST_DIV_CTRL;
      regs[3] <= RST_RSVD_THREE;
      regs[4] <= RST_DIV_CTRL;
      regs[5] <= RST_CHIP_EN;
      regs[6] <= RST_OUT_EN_LO;
    end else if (wr_stb && wr_ofs < 7'(NUM_BYTES) && wr_ofs != OFS_REVISION) begin
      // R15 only addressed byte changes
      if (wr_ofs == OFS_CHIP_EN)
        regs[5] <= (wr_val & ~RO_MASK_CHIP) | RO_MASK_CHIP;
      else
        regs[wr_ofs[2:0]] <= wr_val;
    end
  end

  // ***************************************************
  // dividers and outputs
  // ***************************************************
  cfcs_div_if up_if ();
  cfcs_div_if lo_if ();

  // R09 R10 upper group control
  assign up_if.ratio_sel = regs[OFS_UPPER_DIV[2:0]][RATIO_W-1:0];
  assign up_if.group_on  = regs[OFS_UPPER_DIV[2:0]][GROUP_ON_BIT] & chip_on;
  // R11 R12 lower group control
  assign lo_if.ratio_sel = regs[OFS_LOWER_DIV[2:0]][RATIO_W-1:0];
  assign lo_if.group_on  = regs[OFS_LOWER_DIV[2:0]][GROUP_ON_BIT] & chip_on;

  // R16 R19 divide immediately
  cfcs_divider u_upper (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .src_clk_en (src_clk_en),
    .dif        (up_if.div)
  );

  cfcs_divider u_lower (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .src_clk_en (src_clk_en),
    .dif        (lo_if.div)
  );

  // R13 chip enable
  assign chip_on = regs[OFS_CHIP_EN[2:0]][CHIP_EN_BIT];

  // R14 R20 per output enables
  logic [9:0] next_drive;
  always_comb begin
    next_drive[9:6] = regs[5][5:2];
    next_drive[5:4] = regs[5][1:0];
    next_drive[3:0] = regs[6][7:4];
    next_drive[9:5] = next_drive[9:5] & {5{up_if.group_on}};
    next_drive[4:0] = next_drive[4:0] & {5{lo_if.group_on}};
  end

  // R18 disabled pair sits high
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_drive_on <= 10'h000;
      clk_out_pos  <= 10'h3FF;
      clk_out_neg  <= 10'h3FF;
    end else begin
      out_drive_on <= next_drive;
      for (int i = 0; i < 10; i++) begin
        if (next_drive[i]) begin
          clk_out_pos[i] <= (i > 4) ? up_if.div_out : lo_if.div_out;
          clk_out_neg[i] <= (i > 4) ? ~up_if.div_out : ~lo_if.div_out;
        end else begin
          clk_out_pos[i] <= 1'b1;
          clk_out_neg[i] <= 1'b1;
        end
      end
    end
  end

endmodule

// file: verification/cfcs_slave_checker.sv
`timescale 1ns/1ps
module cfcs_slave_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  // straps and link
  input wire logic       addr_sel_pin_hi,
  input wire logic       addr_sel_pin_lo,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // fanout
  input wire logic       src_clk_en,
  input wire logic [9:0] clk_out_pos,
  input wire logic [9:0] clk_out_neg,
  input wire logic [9:0] out_drive_on,
  input wire logic       chip_on
);
  // ****
  // link activity and reset counters
  // ****
  logic       scl_q;
  logic [4:0] since_fall;
  logic [1:0] since_rst;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      scl_q <= 1'b1;
    else
      scl_q <= scl_in;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      since_fall <= 5'h1F;
    else if (scl_q && !scl_in)
      since_fall <= 5'h00;
    else if (since_fall != 5'h1F)
      since_fall <= since_fall + 5'h01;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      since_rst <= 2'h0;
    else if (since_rst != 2'h3)
      since_rst <= since_rst + 2'h1;
  end
  // ****
  // properties
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_sda_low;
    sda_oe |-> !sda_out;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda driven high");
  property p_oe_scl;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("sda moved while scl high");
  property p_oe_hold;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda pulse too short");
  property p_rst_on;
    $rose(nrst) |-> ##[0:2] out_drive_on == 10'h3FF;
  endproperty
  a_rst_on: assert property (p_rst_on) else $error("outputs off after reset");
  property p_float;
    $stable(out_drive_on) && $past(out_drive_on, 2) == out_drive_on
      |-> ((clk_out_pos & clk_out_neg) | out_drive_on) == 10'h3FF;
  endproperty
  a_float: assert property (p_float) else $error("disabled output not high");
  property p_diff;
    $stable(out_drive_on) && $past(out_drive_on, 2) == out_drive_on
      |-> ((clk_out_pos ^ clk_out_neg) | ~out_drive_on) == 10'h3FF;
  endproperty
  a_diff: assert property (p_diff) else $error("enabled pair not complementary");
  property p_chip_off;
    $fell(chip_on) |-> ##[1:3] out_drive_on == 10'h000;
  endproperty
  a_chip_off: assert property (p_chip_off) else $error("outputs on with chip off");
  property p_chip_gate;
    $rose(|out_drive_on) |-> chip_on;
  endproperty
  a_chip_gate: assert property (p_chip_gate) else $error("output on while chip off");
  property p_bus_only;
    $changed(out_drive_on) && since_rst == 2'h3 |-> since_fall <= 5'd12;
  endproperty
  a_bus_only: assert property (p_bus_only) else $error("enable moved off a write");
  property p_chip_bus;
    $changed(chip_on) |-> since_fall <= 5'd12;
  endproperty
  a_chip_bus: assert property (p_chip_bus) else $error("chip enable moved off a write");
  c_ack: cover property ($rose(sda_oe));
  c_chip: cover property ($fell(chip_on));
  c_low: cover property (out_drive_on[4:0] == 5'h00 && chip_on);
endmodule

bind cfcs_slave cfcs_slave_checker cfcs_slave_checker_inst (
  .ref_clk(ref_clk), .nrst(nrst), .addr_sel_pin_hi(addr_sel_pin_hi), .addr_sel_pin_lo(addr_sel_pin_lo),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .src_clk_en(src_clk_en),
  .clk_out_pos(clk_out_pos), .clk_out_neg(clk_out_neg), .out_drive_on(out_drive_on), .chip_on(chip_on)
);

// file: verification/cfcs_mst.sv
`timescale 1ns/1ps
module cfcs_mst (
  // clock
  input wire logic ref_clk,
  // link lines
  input wire logic sda_bus,
  output logic     scl_drv,
  output logic     sda_low
);
  initial begin
    scl_drv = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic start_cond();
    sda_low <= 1'b0;
    wait_clk(5);
    scl_drv <= 1'b1;
    wait_clk(5);
    sda_low <= 1'b1;
    wait_clk(5);
    scl_drv <= 1'b0;
    wait_clk(5);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    wait_clk(5);
    scl_drv <= 1'b1;
    wait_clk(5);
    sda_low <= 1'b0;
    wait_clk(10);
  endtask
  // data moves only while scl low
  task automatic xfer_bit(input logic b, output logic r);
    sda_low <= !b;
    wait_clk(5);
    scl_drv <= 1'b1;
    wait_clk(5);
    r = sda_bus;
    wait_clk(5);
    scl_drv <= 1'b0;
    wait_clk(5);
  endtask
  // msb first, ninth bit is the ack
  task automatic send_byte(input logic [7:0] d, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    acked = !r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(1'b1, d[i]);
    xfer_bit(last, r);
  endtask
endmodule

// file: verification/tb_clock_fanout_config_slave.sv
`timescale 1ns/1ps
module tb_clock_fanout_config_slave import cfcs_pkg::*;;
  localparam logic [2:0] REVISION_FIELD = 3'h6;  // arbitrary value
  logic       ref_clk;
  logic       nrst;
  logic       addr_sel_pin_hi;
  logic       addr_sel_pin_lo;
  logic       src_clk_en;
  logic       sda_out;
  logic       sda_oe;
  logic       scl_drv;
  logic       sda_low;
  logic       sda_bus;
  logic [9:0] clk_out_pos;
  logic [9:0] clk_out_neg;
  logic [9:0] out_drive_on;
  logic       chip_on;
  logic [6:0] dev;
  int         n_errors;
  int         tests_run;
  assign sda_bus = !sda_low && (sda_oe ? sda_out : 1'b1);
  cfcs_slave #(.REVISION_CODE(REVISION_FIELD)) cfcs_slave_inst (
    .ref_clk(ref_clk), .nrst(nrst), .addr_sel_pin_hi(addr_sel_pin_hi), .addr_sel_pin_lo(addr_sel_pin_lo),
    .scl_in(scl_drv), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .src_clk_en(src_clk_en),
    .clk_out_pos(clk_out_pos), .clk_out_neg(clk_out_neg), .out_drive_on(out_drive_on), .chip_on(chip_on)
  );
  cfcs_mst cfcs_mst_inst (.ref_clk(ref_clk), .sda_bus(sda_bus), .scl_drv(scl_drv), .sda_low(sda_low));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = !ref_clk;
  end
  always @(posedge ref_clk) src_clk_en <= !src_clk_en;
  // ****
  // checking and bus tasks
  // ****
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [6:0] ofs, input logic [7:0] b0, input logic [7:0] b1, input int n);
    logic a;
    cfcs_mst_inst.start_cond();
    cfcs_mst_inst.send_byte({dev, 1'b0}, a);
    cfcs_mst_inst.send_byte({1'b1, ofs}, a);
    chk_flag(a, 1'b1, "cmd ack");
    cfcs_mst_inst.send_byte(b0, a);
    if (n > 1)
      cfcs_mst_inst.send_byte(b1, a);
    chk_flag(a, 1'b1, "data ack");
    cfcs_mst_inst.stop_cond();
  endtask
  task automatic rd(input logic [6:0] ofs, input int n, output logic [7:0] q [7]);
    logic a;
    cfcs_mst_inst.start_cond();
    cfcs_mst_inst.send_byte({dev, 1'b0}, a);
    cfcs_mst_inst.send_byte({1'b1, ofs}, a);
    cfcs_mst_inst.start_cond();
    cfcs_mst_inst.send_byte({dev, 1'b1}, a);
    chk_flag(a, 1'b1, "read addr ack");
    for (int i = 0; i < n; i++)
      cfcs_mst_inst.get_byte(i == n - 1, q[i]);
    cfcs_mst_inst.stop_cond();
  endtask
  task automatic period(input int b, output int n);
    logic prev;
    int   edges;
    n = 0;
    edges = 0;
    prev = clk_out_pos[b];
    for (int c = 0; c < 1000 && edges < 2; c++) begin
      @(posedge ref_clk);
      if (edges == 1)
        n++;
      if (!prev && clk_out_pos[b])
        edges++;
      prev = clk_out_pos[b];
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_defaults();
    logic [7:0] q [7];
    logic [7:0] e [7];
    e = '{{2'b00, REVISION_FIELD, 3'b000}, 8'h20, 8'h30, 8'h00, 8'h30, 8'hFF, 8'hF0};
    chk(out_drive_on, 10'h3FF, "drive after reset");
    wr(7'h00, 8'hFF, 8'h00, 1);
    rd(7'h00, 7, q);
    for (int i = 0; i < 7; i++)
      chk({2'b00, q[i]}, {2'b00, e[i]}, "reset byte");
  endtask
  task automatic t_addr();
    logic       a;
    logic [6:0] ad;
    for (int p = 0; p < 4; p++) begin
      addr_sel_pin_hi <= p[1];
      addr_sel_pin_lo <= p[0];
      for (int t = 0; t < 5; t++) begin
        ad = (t == 4) ? {5'h0B, p[1:0]} : {5'h1A, t[1:0]};
        cfcs_mst_inst.start_cond();
        cfcs_mst_inst.send_byte({ad, 1'b0}, a);
        chk_flag(a, t == p, "address match");
        cfcs_mst_inst.stop_cond();
      end
    end
  endtask
  task automatic t_cmd();
    logic a;
    cfcs_mst_inst.start_cond();
    cfcs_mst_inst.send_byte({dev, 1'b0}, a);
    cfcs_mst_inst.send_byte(8'h05, a);
    chk_flag(a, 1'b0, "cmd without op flag");
    cfcs_mst_inst.stop_cond();
  endtask
  task automatic t_write();
    logic [7:0] q [7];
    wr(7'h02, 8'h35, 8'h00, 1);
    wr(7'h05, 8'hC3, 8'h50, 2);
    chk(out_drive_on, 10'h035, "single enables");
    chk({clk_out_pos[3], clk_out_neg[3]}, 10'h003, "disabled lines");
    rd(7'h05, 2, q);
    chk({q[0], q[1][7:6]}, {8'hC3, 2'b01}, "word read");
    rd(7'h02, 1, q);
    chk({2'b00, q[0]}, 10'h035, "ratio readback");
    wr(7'h05, 8'h7F, 8'hF0, 2);
    chk({chip_on, out_drive_on[8:0]}, 10'h000, "chip off");
    wr(7'h05, 8'hFF, 8'hF0, 2);
    wr(7'h04, 8'h10, 8'h00, 1);
    chk(out_drive_on, 10'h3E0, "lower group off");
    wr(7'h03, 8'h00, 8'h30, 2);
    wr(7'h02, 8'h10, 8'h00, 1);
    chk(out_drive_on, 10'h01F, "upper group off");
    wr(7'h02, 8'h30, 8'h00, 1);
    chk(out_drive_on, 10'h3FF, "all back on");
  endtask
  task automatic t_ratio();
    int rt [11];
    int n;
    rt = '{1, 2, 4, 5, 8, 10, 16, 20, 32, 40, 80};
    for (int k = 0; k < 11; k++) begin
      wr(7'h04, {4'h3, k[3:0]}, 8'h00, 1);
      period(0, n);
      period(0, n);
      chk(n[9:0], 10'(4 * rt[k]), "lower period");
      period(9, n);
      chk(n[9:0], 10'h004, "upper period");
    end
  endtask
  initial begin
    #600000;
    n_errors++;
    conclude();
  end
  initial begin
    nrst = 1'b0;
    addr_sel_pin_hi = 1'b1;
    addr_sel_pin_lo = 1'b1;
    src_clk_en = 1'b0;
    n_errors = 0;
    tests_run = 0;
    dev = 7'h6B;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_defaults();
    t_addr();
    t_cmd();
    t_write();
    t_ratio();
    conclude();
  end
endmodule
